/* File: fbsq_seq.sv */
// Notes on behaviour
// - Sequences open with AA@555, 55@2AA unlocks
// - Code 25 in sector enters buffer load
// - Confirm 29 at sector starts array transfer
// - Program sequence spans six to 37 writes
// - Unlocks then F0@555 leave abort state
// - Erase preprograms to zero, then erases
// - Erased words read back as array data (model: address ^ 5a5a), not all ones
// - Window after erase command accepts more sectors
// - Window starts at final command write
// - Sectors queue any order, each before timeout
// - Late sector write: ignored here, erase runs on
// - Other write in window cancels, bank reads
// - Status bit shows window expired
// - Erase done returns bank to array read
// - Erasing bank reads return polling and toggles
// - During erase only suspend is honoured
// - Reset stops any operation at once
// - Erase is six writes: unlocks, 80, unlocks, 30
// - Abort on big count, sector, page, confirm
// - Abort status: flag 1, poll inverted, toggle
`timescale 1ns/1ps
`default_nettype none
module fbsq_seq (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [23:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic [15:0] i_arr_rdata,
   output fbsq_pkg::fbsq_acmd_t o_arr_cmd,
   output logic [23:0] o_arr_addr,
   output logic [15:0] o_arr_data,
   output logic o_arr_req,
   input wire logic i_arr_done,
   output logic o_busy,
   output logic o_erase_suspend
);
   function automatic logic [7:0] sect_of(input logic [23:0] a);
      sect_of = a[23:16];
   endfunction

   function automatic logic [7:0] low_sect(input logic [255:0] m);
      low_sect = 8'h00;
      for (int i = fbsq_pkg::NSECT - 1; i >= 0; i--)
         if (m[i]) low_sect = 8'(i);
   endfunction

   function automatic logic [15:0] bank_mask(input logic [255:0] m);
      bank_mask = 16'h0000;
      for (int i = 0; i < fbsq_pkg::NSECT; i++)
         if (m[i]) bank_mask[i >> 4] = 1'b1;
   endfunction

   fbsq_pkg::fbsq_state_t state_q, state_d;
   logic [7:0] sect_q;
   logic [5:0] cnt_q;
   logic [18:0] page_q;
   logic page_set_q;
   logic [15:0] last_data_q;
   logic [5:0] prog_idx_q;
   logic wait_q;
   logic phase_q;
   logic [255:0] mask_q;
   logic [11:0] win_cnt_q;
   logic tog_q;
   logic etog_q;
   logic [15:0] rdata_q;
   logic arr_req_q;
   fbsq_pkg::fbsq_acmd_t arr_cmd_q;
   logic [23:0] arr_addr_q;
   logic [15:0] arr_data_q;
   logic suspend_q;
   logic [15:0] stat;

   fbsq_buf_if wb ();

   fbsq_wbuf u_wbuf (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .bus(wb.store)
   );

   // Write decoding
   wire is_a = i_addr[11:0] == fbsq_pkg::OFS_A;
   wire is_b = i_addr[11:0] == fbsq_pkg::OFS_B;
   wire wr_unl1 = i_wr && is_a && i_wdata == fbsq_pkg::CD_UNL1;
   wire wr_unl2 = i_wr && is_b && i_wdata == fbsq_pkg::CD_UNL2;
   wire wr_25 = i_wr && i_wdata == fbsq_pkg::CD_BUFLOAD;
   wire wr_29 = i_wr && i_wdata == fbsq_pkg::CD_CONFIRM;
   wire wr_30 = i_wr && i_wdata == fbsq_pkg::CD_SECT_ERS;
   wire wr_b0 = i_wr && i_wdata == fbsq_pkg::CD_SUSPEND;
   wire wr_80a = i_wr && is_a && i_wdata == fbsq_pkg::CD_ERS_SETUP;
   wire wr_f0a = i_wr && is_a && i_wdata == fbsq_pkg::CD_ABORT_RST;
   wire [7:0] wsect = sect_of(i_addr);
   wire same_sect = wsect == sect_q;
   wire same_page = i_addr[23:5] == page_q;
   wire cnt_bad = i_wdata > fbsq_pkg::MAX_COUNT || !same_sect;
   wire load_bad = !same_sect || (page_set_q && !same_page);
   wire load_ok = state_q == fbsq_pkg::S_WB_LOAD && i_wr && !load_bad;
   wire cnt_wr = state_q == fbsq_pkg::S_WB_CNT && i_wr;

   // Status decoding
   wire in_prog = state_q == fbsq_pkg::S_WB_PROG;
   wire in_win = state_q == fbsq_pkg::S_WIN;
   wire in_run = state_q == fbsq_pkg::S_RUN;
   wire abort_st = state_q inside {fbsq_pkg::S_ABORT, fbsq_pkg::S_AB_U1, fbsq_pkg::S_AB_U2};
   wire [3:0] rd_bank = i_addr[23:20];
   wire [15:0] ers_banks = bank_mask(mask_q);
   wire ers_hit = (in_win || in_run) && ers_banks[rd_bank];
   wire prg_hit = (in_prog || abort_st) && rd_bank == sect_q[7:4];
   wire rd_busy = ers_hit || prg_hit;
   wire ers_sect_hit = ers_hit && mask_q[sect_of(i_addr)];

   // Array engine decoding
   wire prog_done = prog_idx_q == 6'(fbsq_pkg::BUF_WORDS);
   wire mask_empty = mask_q == '0;
   wire [7:0] eng_sect = low_sect(mask_q);
   wire prog_issue = in_prog && !wait_q && !prog_done && wb.rd_valid;
   wire prog_skip = in_prog && !wait_q && !prog_done && !wb.rd_valid;
   wire ers_issue = in_run && !wait_q && !mask_empty;
   wire sect_add = wr_30 && (state_q == fbsq_pkg::S_EU2 || in_win);
   wire win_cancel = in_win && i_wr && !wr_30 && !wr_b0;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         fbsq_pkg::S_IDLE: begin
            if (wr_unl1) state_d = fbsq_pkg::S_U1;
         end
         fbsq_pkg::S_U1: begin
            if (i_wr) state_d = wr_unl2 ? fbsq_pkg::S_U2 : fbsq_pkg::S_IDLE;
         end
         fbsq_pkg::S_U2: begin
            if (wr_25) state_d = fbsq_pkg::S_WB_CNT;
            else if (wr_80a) state_d = fbsq_pkg::S_ES;
            else if (i_wr) state_d = fbsq_pkg::S_IDLE;
         end
         fbsq_pkg::S_WB_CNT: begin
            if (i_wr) state_d = cnt_bad ? fbsq_pkg::S_ABORT : fbsq_pkg::S_WB_LOAD;
         end
         fbsq_pkg::S_WB_LOAD: begin
            if (i_wr && load_bad) state_d = fbsq_pkg::S_ABORT;
            else if (i_wr && cnt_q == 6'd1) state_d = fbsq_pkg::S_WB_CONF;
         end
         fbsq_pkg::S_WB_CONF: begin
            if (i_wr) begin
               state_d = (wr_29 && same_sect) ? fbsq_pkg::S_WB_PROG : fbsq_pkg::S_ABORT;
            end
         end
         fbsq_pkg::S_WB_PROG: begin
            if (!wait_q && prog_done) state_d = fbsq_pkg::S_IDLE;
         end
         fbsq_pkg::S_ABORT: begin
            if (wr_unl1) state_d = fbsq_pkg::S_AB_U1;
         end
         fbsq_pkg::S_AB_U1: begin
            if (i_wr) state_d = wr_unl2 ? fbsq_pkg::S_AB_U2 : fbsq_pkg::S_ABORT;
         end
         fbsq_pkg::S_AB_U2: begin
            if (i_wr) state_d = wr_f0a ? fbsq_pkg::S_IDLE : fbsq_pkg::S_ABORT;
         end
         fbsq_pkg::S_ES: begin
            if (i_wr) state_d = wr_unl1 ? fbsq_pkg::S_EU1 : fbsq_pkg::S_IDLE;
         end
         fbsq_pkg::S_EU1: begin
            if (i_wr) state_d = wr_unl2 ? fbsq_pkg::S_EU2 : fbsq_pkg::S_IDLE;
         end
         fbsq_pkg::S_EU2: begin
            if (i_wr) state_d = wr_30 ? fbsq_pkg::S_WIN : fbsq_pkg::S_IDLE;
         end
         fbsq_pkg::S_WIN: begin
            if (win_cancel) state_d = fbsq_pkg::S_IDLE;
            else if (wr_b0) state_d = fbsq_pkg::S_RUN;
            else if (!wr_30 && win_cnt_q == 12'h000) state_d = fbsq_pkg::S_RUN;
         end
         fbsq_pkg::S_RUN: begin
            if (!wait_q && mask_empty) state_d = fbsq_pkg::S_IDLE;
         end
         default: state_d = fbsq_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) state_q <= fbsq_pkg::S_IDLE;
      else state_q <= state_d;
   end

   // Buffer loading
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         sect_q <= 8'h00;
         cnt_q <= 6'h00;
         page_set_q <= 1'b0;
      end else begin
         if (state_q == fbsq_pkg::S_U2 && wr_25) sect_q <= wsect;
         if (cnt_wr) cnt_q <= i_wdata[5:0] + 6'h01;
         else if (load_ok) cnt_q <= cnt_q - 6'h01;
         if (cnt_wr) page_set_q <= 1'b0;
         else if (load_ok) page_set_q <= 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         page_q <= 19'h00000;
         last_data_q <= 16'h0000;
      end else if (load_ok) begin
         if (!page_set_q) page_q <= i_addr[23:5];
         last_data_q <= i_wdata;
      end
   end

   assign wb.clr = cnt_wr;
   assign wb.wr_en = load_ok;
   assign wb.wr_idx = i_addr[4:0];
   assign wb.wr_data = i_wdata;
   assign wb.rd_idx = prog_idx_q[4:0];

   // Array engine: buffered words, then queued sectors
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         prog_idx_q <= 6'h00;
         wait_q <= 1'b0;
         phase_q <= 1'b0;
      end else begin
         if (!in_prog) prog_idx_q <= 6'h00;
         else if (prog_skip || (wait_q && i_arr_done)) prog_idx_q <= prog_idx_q + 6'h01;
         if (prog_issue || ers_issue) wait_q <= 1'b1;
         else if (i_arr_done) wait_q <= 1'b0;
         if (!in_run) phase_q <= 1'b0;
         else if (wait_q && i_arr_done) phase_q <= !phase_q;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || win_cancel) mask_q <= '0;
      else if (sect_add) mask_q[wsect] <= 1'b1;
      else if (in_run && wait_q && i_arr_done && phase_q) mask_q[eng_sect] <= 1'b0;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) win_cnt_q <= 12'h000;
      else if (sect_add) win_cnt_q <= 12'(fbsq_pkg::WIN_CYC);
      else if (in_win && win_cnt_q != 12'h000) win_cnt_q <= win_cnt_q - 12'h001;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         arr_req_q <= 1'b0;
         arr_cmd_q <= fbsq_pkg::ACMD_NOP;
         arr_addr_q <= 24'h000000;
         arr_data_q <= 16'h0000;
      end else begin
         arr_req_q <= prog_issue || ers_issue;
         if (prog_issue) begin
            arr_cmd_q <= fbsq_pkg::ACMD_PROG;
            arr_addr_q <= {page_q, prog_idx_q[4:0]};
            arr_data_q <= wb.rd_data;
         end else if (ers_issue) begin
            arr_cmd_q <= phase_q ? fbsq_pkg::ACMD_ERASE : fbsq_pkg::ACMD_PREPROG;
            arr_addr_q <= {eng_sect, 16'h0000};
            arr_data_q <= 16'h0000;
         end
      end
   end

   // Only suspend is honoured once erasing; other writes fall through
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) suspend_q <= 1'b0;
      else suspend_q <= wr_b0 && (in_win || in_run);
   end

   // Status reads
   always_comb begin
      stat = 16'h0000;
      stat[fbsq_pkg::ST_POLL] = ers_hit ? 1'b0 : !last_data_q[7];
      stat[fbsq_pkg::ST_TOG] = tog_q;
      stat[fbsq_pkg::ST_TLIM] = 1'b0;
      stat[fbsq_pkg::ST_TMR] = in_run;
      stat[fbsq_pkg::ST_ETOG] = etog_q;
      stat[fbsq_pkg::ST_ABORT] = abort_st;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         tog_q <= 1'b0;
         etog_q <= 1'b0;
         rdata_q <= fbsq_pkg::RDATA_RST;
      end else if (i_rd) begin
         if (rd_busy) tog_q <= !tog_q;
         if (ers_sect_hit) etog_q <= !etog_q;
         rdata_q <= rd_busy ? stat : i_arr_rdata;
      end
   end

   assign o_rdata = rdata_q;
   assign o_arr_req = arr_req_q;
   assign o_arr_cmd = arr_cmd_q;
   assign o_arr_addr = arr_addr_q;
   assign o_arr_data = arr_data_q;
   assign o_busy = in_prog || in_win || in_run;
   assign o_erase_suspend = suspend_q;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   a_unlock_step: assert property (
      state_q == fbsq_pkg::S_IDLE && wr_unl1 ##1 wr_unl2 |=> state_q == fbsq_pkg::S_U2)
      else $error("unlock pair not recognised");
   a_bufload_entry: assert property (
      state_q == fbsq_pkg::S_U2 && wr_25 |=> state_q == fbsq_pkg::S_WB_CNT && sect_q == $past(wsect))
      else $error("buffer load command not taken");
   a_count_decr: assert property (
      load_ok |=> cnt_q == $past(cnt_q) - 6'h01)
      else $error("remaining count not decremented");
   a_big_count: assert property (
      cnt_wr && i_wdata > fbsq_pkg::MAX_COUNT |=> state_q == fbsq_pkg::S_ABORT)
      else $error("oversize count did not abort");
   a_confirm_go: assert property (
      state_q == fbsq_pkg::S_WB_CONF && wr_29 && same_sect |=> in_prog ##1 o_busy)
      else $error("confirm did not start programming");
   a_abort_exit: assert property (
      state_q == fbsq_pkg::S_AB_U2 && wr_f0a |=> state_q == fbsq_pkg::S_IDLE && !abort_st)
      else $error("abort reset did not return to read");
   a_abort_status: assert property (
      i_rd && abort_st && rd_bank == sect_q[7:4]
      |=> o_rdata[1] && !o_rdata[5] && o_rdata[7] == !last_data_q[7])
      else $error("abort status word wrong");
   a_window_start: assert property (
      state_q == fbsq_pkg::S_EU2 && wr_30 |=> in_win && win_cnt_q == 12'(fbsq_pkg::WIN_CYC))
      else $error("erase window not started");
   a_window_cancel: assert property (
      win_cancel |=> state_q == fbsq_pkg::S_IDLE && mask_q == '0 && !o_busy)
      else $error("foreign write did not cancel window");
   a_window_bit: assert property (
      i_rd && ers_hit |=> o_rdata[3] == $past(in_run))
      else $error("window expired bit wrong");
   a_run_ignore: assert property (
      in_run && i_wr && !wr_b0 |=> (in_run || state_q == fbsq_pkg::S_IDLE) && !o_erase_suspend)
      else $error("write disturbed running erase");
   a_break_idle: assert property (
      state_q == fbsq_pkg::S_U1 && i_wr && !wr_unl2 |=> state_q == fbsq_pkg::S_IDLE)
      else $error("broken unlock not discarded");
   a_reset_stop: assert property (@(posedge i_clk_sys) disable iff (1'b0)
      i_reset |=> state_q == fbsq_pkg::S_IDLE && !o_busy && !o_arr_req)
      else $error("reset did not stop operation");

   c_prog_done: cover property (in_prog ##1 state_q == fbsq_pkg::S_IDLE);
   c_abort: cover property (state_q == fbsq_pkg::S_WB_LOAD ##1 state_q == fbsq_pkg::S_ABORT);
   c_two_sect: cover property (in_win && sect_add ##[1:10] in_run);
   c_erase_done: cover property (in_run ##1 state_q == fbsq_pkg::S_IDLE);
endmodule
`default_nettype wire

/* File: fbsq_pkg.sv */
package fbsq_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int BUF_WORDS = 32;
   localparam int IDX_W = 5;
   localparam int SECT_LSB = 16;
   localparam int SECT_W = 8;
   localparam int NSECT = 256;
   localparam int BANK_W = 4;
   localparam int NBANK = 16;
   localparam int PAGE_LSB = 5;
   localparam int PAGE_W = 19;
   localparam logic [11:0] OFS_A = 12'h555;
   localparam logic [11:0] OFS_B = 12'h2aa;
   localparam logic [15:0] CD_UNL1 = 16'h00aa;
   localparam logic [15:0] CD_UNL2 = 16'h0055;
   localparam logic [15:0] CD_BUFLOAD = 16'h0025;
   localparam logic [15:0] CD_CONFIRM = 16'h0029;
   localparam logic [15:0] CD_ABORT_RST = 16'h00f0;
   localparam logic [15:0] CD_ERS_SETUP = 16'h0080;
   localparam logic [15:0] CD_SECT_ERS = 16'h0030;
   localparam logic [15:0] CD_SUSPEND = 16'h00b0;
   localparam logic [15:0] MAX_COUNT = 16'h001f;
   localparam int CLK_NS = 20;
   localparam int ERASE_ACCEPT_WINDOW_NS = 50000;
   localparam int WIN_CYC = (ERASE_ACCEPT_WINDOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int WIN_W = 12;
   localparam int ST_POLL = 7;
   localparam int ST_TOG = 6;
   localparam int ST_TLIM = 5;
   localparam int ST_TMR = 3;
   localparam int ST_ETOG = 2;
   localparam int ST_ABORT = 1;
   localparam logic [15:0] RDATA_RST = 16'h0000;
   typedef enum logic [1:0] {
      ACMD_NOP = 2'b00,
      ACMD_PROG = 2'b01,
      ACMD_PREPROG = 2'b10,
      ACMD_ERASE = 2'b11
   } fbsq_acmd_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_U1 = 4'b0001,
      S_U2 = 4'b0010,
      S_WB_CNT = 4'b0011,
      S_WB_LOAD = 4'b0100,
      S_WB_CONF = 4'b0101,
      S_WB_PROG = 4'b0110,
      S_ABORT = 4'b0111,
      S_AB_U1 = 4'b1000,
      S_AB_U2 = 4'b1001,
      S_ES = 4'b1010,
      S_EU1 = 4'b1011,
      S_EU2 = 4'b1100,
      S_WIN = 4'b1101,
      S_RUN = 4'b1110
   } fbsq_state_t;
endpackage

/* File: fbsq_buf_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fbsq_buf_if;
   logic clr;
   logic wr_en;
   logic [4:0] wr_idx;
   logic [15:0] wr_data;
   logic [4:0] rd_idx;
   logic [15:0] rd_data;
   logic rd_valid;
   modport master (output clr, output wr_en, output wr_idx, output wr_data,
                   output rd_idx, input rd_data, input rd_valid);
   modport store (input clr, input wr_en, input wr_idx, input wr_data,
                  input rd_idx, output rd_data, output rd_valid);
endinterface
`default_nettype wire

/* File: fbsq_wbuf.sv */
`timescale 1ns/1ps
`default_nettype none
module fbsq_wbuf (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   fbsq_buf_if.store bus
);
   logic [15:0] mem_q [fbsq_pkg::BUF_WORDS];
   logic [fbsq_pkg::BUF_WORDS-1:0] vld_q;

   // Reloading a slot overwrites it; last data wins
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || bus.clr) begin
         vld_q <= '0;
      end else if (bus.wr_en) begin
         vld_q[bus.wr_idx] <= 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (bus.wr_en) begin
         mem_q[bus.wr_idx] <= bus.wr_data;
      end
   end

   assign bus.rd_data = mem_q[bus.rd_idx];
   assign bus.rd_valid = vld_q[bus.rd_idx];
endmodule
`default_nettype wire

/* File: fbsq_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fbsq_array_model (
   input wire logic i_clk_sys,
   input wire logic i_req,
   input wire logic [7:0] i_lat,
   input wire logic [23:0] i_addr,
   output logic o_done,
   output logic [15:0] o_rdata
);
   logic [7:0] cnt_q = 8'h00;
   // Array contents are a fixed function of the address
   assign o_rdata = i_addr[15:0] ^ 16'h5a5a;
   // Each command ends after the chosen latency; reset does not stop it
   always_ff @(posedge i_clk_sys) begin
      if (i_req) begin
         cnt_q <= i_lat;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
   assign o_done = (cnt_q == 8'h01);
endmodule
`default_nettype wire

/* File: buffer_program_sector_erase_seq_test.sv */
`timescale 1ns/1ps
`default_nettype none
module buffer_program_sector_erase_seq_test;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic [23:0] i_addr = 24'h000000;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] o_rdata;
   logic [15:0] arr_rdata;
   fbsq_pkg::fbsq_acmd_t o_arr_cmd;
   logic [23:0] o_arr_addr;
   logic [15:0] o_arr_data;
   logic o_arr_req;
   logic arr_done;
   logic o_busy;
   logic o_erase_suspend;
   logic [7:0] lat = 8'h06;
   logic rd_seen = 1'b0;
   logic [31:0] rng = 32'ha4ed2bd2;
   logic [41:0] arr_q[$];
   logic [31:0] rd_q[$];
   int n_mismatch = 0;
   int tests_run = 0;
   int n_susp = 0;
   int cyc = 0;

   fbsq_seq dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_arr_rdata(arr_rdata), .o_arr_cmd(o_arr_cmd), .o_arr_addr(o_arr_addr),
      .o_arr_data(o_arr_data), .o_arr_req(o_arr_req), .i_arr_done(arr_done),
      .o_busy(o_busy), .o_erase_suspend(o_erase_suspend));
   fbsq_array_model u_array (.i_clk_sys(i_clk_sys), .i_req(o_arr_req), .i_lat(lat),
      .i_addr(i_addr), .o_done(arr_done), .o_rdata(arr_rdata));

   initial begin
      forever #10 i_clk_sys = ~i_clk_sys;
   end

   function automatic logic [31:0] xs();
      logic [31:0] x;
      x = rng;
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      rng = x;
      return x;
   endfunction

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [41:0] seen, input logic [41:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [23:0] a, input logic [15:0] d);
      i_wr <= 1'b1;
      i_rd <= 1'b0;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
   endtask

   // Mask and value of the expected read data go to the queue
   task automatic rd(input logic [23:0] a, input logic [15:0] m, input logic [15:0] v);
      rd_q.push_back({m, v});
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
   endtask

   task automatic idle(input int n);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      repeat (n) @(posedge i_clk_sys);
   endtask

   task automatic arr_rd(input logic [23:0] a);
      rd(a, 16'hffff, a[15:0] ^ 16'h5a5a);
   endtask

   task automatic unlock();
      wr(24'h000555, 16'h00aa);
      wr(24'h0002aa, 16'h0055);
   endtask

   task automatic wait_idle(input int n);
      idle(1);
      while (o_busy !== 1'b0 && n > 0) begin
         @(posedge i_clk_sys);
         n--;
      end
      chk("busy", o_busy, 42'h0);
   endtask

   task automatic prog(input int n, input logic [7:0] s);
      logic [15:0] bd[32];
      logic [31:0] used;
      logic [18:0] pg;
      logic [4:0] sl;
      pg = {s, 11'(xs())};
      used = '0;
      unlock();
      wr({s, 16'h0000}, 16'h0025);
      wr({s, 16'h0000}, 16'(n - 1));
      for (int i = 0; i < n; i++) begin
         sl = 5'(xs());
         bd[sl] = 16'(xs());
         used[sl] = 1'b1;
         wr({pg, sl}, bd[sl]);
      end
      wr({s, 16'h0000}, 16'h0029);
      for (int i = 0; i < 32; i++) begin
         if (used[i]) begin
            arr_q.push_back({2'h1, pg, 5'(i), bd[i]});
         end
      end
      rd({s, 16'h0000}, 16'h00a2, {8'h00, ~bd[sl][7], 7'h00});
      wait_idle(5000);
      arr_rd({s, 16'h0040});
   endtask

   task automatic abort_case(input int k);
      logic [7:0] s;
      logic [15:0] d;
      s = 8'h40 + 8'(k);
      d = 16'(xs());
      unlock();
      wr({s, 16'h0000}, 16'h0025);
      wr({s, 16'h0000}, (k == 0) ? 16'h0020 : 16'h0001);
      if (k == 1) wr({s + 8'h01, 16'h0000}, d);
      if (k >= 2) wr({s, 16'h0100}, d);
      if (k == 2) wr({s, 16'h0200}, d);
      if (k == 3) wr({s, 16'h0101}, d);
      if (k == 3) wr({s, 16'h0000}, 16'h0030);
      rd({s, 16'h0000}, (k >= 2) ? 16'h00a2 : 16'h0022, {8'h00, ~d[7] & (k >= 2), 7'h02});
      wr(24'h000555, 16'h1234);
      rd({s, 16'h0000}, 16'h0022, 16'h0002);
      unlock();
      wr(24'h000555, 16'h00f0);
      arr_rd({s, 16'h0000});
   endtask

   task automatic erase_seq(input logic [7:0] s);
      unlock();
      wr(24'h000555, 16'h0080);
      unlock();
      wr({s, 16'h0000}, 16'h0030);
   endtask

   task automatic exp_erase(input logic [7:0] s);
      arr_q.push_back({2'h2, s, 32'h0});
      arr_q.push_back({2'h3, s, 32'h0});
   endtask

   always @(posedge i_clk_sys) begin
      logic [31:0] e;
      cyc++;
      if (o_erase_suspend === 1'b1) n_susp++;
      if (o_arr_req === 1'b1) begin
         if (arr_q.size() == 0) chk("arr_extra", 42'h1, 42'h0);
         else chk("arr_cmd", {o_arr_cmd, o_arr_addr, o_arr_data}, arr_q.pop_front());
      end
      if (rd_seen) begin
         e = rd_q.pop_front();
         chk("rdata", o_rdata & e[31:16], e[15:0]);
      end
      rd_seen <= i_rd;
      if (cyc == 60000) begin
         n_mismatch++;
         close_out();
      end
   end

   initial begin
      repeat (2) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      @(posedge i_clk_sys);
      arr_rd(24'h000123);
      wr(24'h000555, 16'h00aa);
      wr(24'h000123, 16'h0055);
      wr(24'h300000, 16'h0025);
      arr_rd(24'h300000);
      prog(1, 8'h31);
      prog(32, 8'h52);
      prog(int'(xs() % 30) + 2, 8'h63);
      for (int k = 0; k < 4; k++) abort_case(k);
      lat <= 8'hc8;
      erase_seq(8'h37);
      wr(24'h120000, 16'h0030);
      exp_erase(8'h12);
      exp_erase(8'h37);
      rd(24'h370000, 16'h0008, 16'h0000);
      idle(2470);
      rd(24'h120000, 16'h0008, 16'h0000);
      idle(40);
      rd(24'h370000, 16'h0008, 16'h0008);
      wr(24'h000555, 16'h00aa);
      arr_rd(24'h000100);
      wait_idle(5000);
      arr_rd(24'h370010);
      lat <= 8'h05;
      erase_seq(8'h25);
      wr(24'h250000, 16'h1234);
      wait_idle(3);
      arr_rd(24'h250000);
      erase_seq(8'h44);
      wr(24'h410000, 16'h0030);
      wr(24'h400000, 16'h00b0);
      exp_erase(8'h41);
      exp_erase(8'h44);
      wait_idle(200);
      chk("suspend", n_susp, 42'h1);
      lat <= 8'h40;
      erase_seq(8'h66);
      wr(24'h600000, 16'h00b0);
      arr_q.push_back({2'h2, 8'h66, 32'h0});
      idle(6);
      i_reset <= 1'b1;
      idle(2);
      i_reset <= 1'b0;
      idle(1);
      chk("busy", o_busy, 42'h0);
      idle(100);
      arr_rd(24'h660000);
      idle(5);
      chk("left", arr_q.size() + rd_q.size(), 42'h0);
      close_out();
   end
endmodule
`default_nettype wire
